// file: src/tsa_core.sv
// Temperature sensor core: control word, limits, conversion pacing,
// alarm modes and the three-wire serial register port.
// Assumes the converter code on i_temp_code is steady when sampled.
`default_nettype none

module tsa_core #(
  parameter int P_CYC_PER_MS = tsa_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_reset,
  // Serial pins
  input  wire logic                      i_cs_n,
  input  wire logic                      i_sck,
  input  wire logic                      i_sio,
  output var  logic                      o_sio,
  output var  logic                      o_sio_oe,
  // Converter and status
  input  wire logic [tsa_pkg::TEMP_W-1:0] i_temp_code,
  output var  logic                      o_converting,
  output var  logic                      o_power_down,
  output var  logic                      o_alert
);
  import tsa_pkg::*;

  typedef enum logic [2:0] {
    ST_CONV = 3'b001,
    ST_IDLE = 3'b010,
    ST_DOWN = 3'b100
  } tsa_state_t;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [2:0] qlen(input logic [1:0] code);
    case (code)
      2'h0:    qlen = QLEN_0;
      2'h1:    qlen = QLEN_1;
      2'h2:    qlen = QLEN_2;
      default: qlen = QLEN_3;
    endcase
  endfunction

  function automatic logic [TEMP_W-1:0] lsb_mask(input logic [1:0] res);
    lsb_mask = TEMP_W'((1 << (RES_FULL - res)) - 1);
  endfunction

  function automatic logic [MS_W-1:0] scale(input logic [MS_W-1:0] ms,
                                            input logic [1:0] res);
    scale = ms >> (RES_FULL - res);
  endfunction

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  tsa_pins_t pin_raw;
  tsa_pins_t pin_lvl;
  tsa_pins_t pin_rise;
  tsa_pins_t pin_fall;

  assign pin_raw = '{cs_n: i_cs_n, sck: i_sck, sio: i_sio};

  tsa_sync #(.W(PIN_W), .IDLE(PIN_IDLE)) u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (pin_raw),
    .o_level (pin_lvl),
    .o_rise  (pin_rise),
    .o_fall  (pin_fall)
  );

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  tsa_ctrl_t         ctrl_reg;
  logic [TEMP_W-1:0] upper_reg;
  logic [TEMP_W-1:0] lower_reg;
  logic [TEMP_W-1:0] temp_reg;
  logic [1:0]        ptr_reg;
  logic [1:0]        rd_sel_reg;
  logic              rd_phase_reg;
  logic              in_frame_reg;
  logic [3:0]        bit_reg;
  logic [WORD_W-1:0] sh_out_reg;
  logic [WORD_W-1:0] sh_in_reg;
  logic              sd_pend_reg;
  tsa_state_t        state_reg;
  logic [31:0]       cyc_reg;
  logic [MS_W-1:0]   ms_reg;
  logic              active_reg;
  logic              arm_low_reg;
  logic              rel_pend_reg;
  logic [2:0]        hi_cnt_reg;
  logic [2:0]        lo_cnt_reg;

  logic              sck_rise;
  logic              last_bit;
  logic              read_done;
  logic              cmd_done;
  logic [WORD_W-1:0] cmd;
  logic              is_sd;
  logic              is_read;
  logic              conv_done;
  logic              enter_down;
  logic              ms_tick;
  logic              hi_now;
  logic              lo_now;
  logic [2:0]        hi_cnt_next;
  logic [2:0]        lo_cnt_next;
  logic              set_evt;
  logic              rel_evt;
  logic              rd_clear;
  logic [1:0]        mode;

  function automatic logic [WORD_W-1:0] rd_word(input logic [1:0] p);
    case (p)
      PTR_CTRL:  rd_word = ctrl_reg;
      PTR_LOWER: rd_word = {lower_reg, LOWER_TAIL};
      PTR_UPPER: rd_word = {upper_reg, UPPER_TAIL};
      default:   rd_word = {temp_reg, TEMP_TAIL};
    endcase
  endfunction

  // ****************************************************************
  // Serial framing
  // ****************************************************************
  assign sck_rise  = pin_rise.sck && in_frame_reg && !pin_lvl.cs_n;
  assign last_bit  = bit_reg == LAST_BIT;
  assign read_done = sck_rise && last_bit && rd_phase_reg;
  assign cmd_done  = sck_rise && last_bit && !rd_phase_reg;
  assign cmd       = {sh_in_reg[WORD_W-2:0], pin_lvl.sio};
  assign is_sd     = cmd[7:0] == SD_PATTERN;
  assign is_read   = cmd[RD_FLAG] && cmd[2:0] == READ_TAIL;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      in_frame_reg <= 1'b0;
      rd_phase_reg <= 1'b1;
      bit_reg      <= '0;
      sh_out_reg   <= '0;
      sh_in_reg    <= '0;
      rd_sel_reg   <= PTR_TEMP;
    end else if (pin_lvl.cs_n) begin
      in_frame_reg <= 1'b0;
      rd_phase_reg <= 1'b1;
      bit_reg      <= '0;
    end else if (!in_frame_reg) begin
      in_frame_reg <= 1'b1;
      sh_out_reg   <= rd_word(ptr_reg);
      rd_sel_reg   <= ptr_reg;
    end else if (sck_rise) begin
      bit_reg   <= bit_reg + 4'h1;
      sh_in_reg <= cmd;
      if (last_bit) begin
        rd_phase_reg <= !rd_phase_reg;
        if (cmd_done) begin
          // Next read phase: commanded register or the result
          sh_out_reg <= rd_word(is_read ? cmd[PTR_MSB:PTR_LSB] : PTR_TEMP);
          rd_sel_reg <= is_read ? cmd[PTR_MSB:PTR_LSB] : PTR_TEMP;
        end
      end
    end else if (pin_fall.sck && rd_phase_reg && bit_reg != '0) begin
      sh_out_reg <= {sh_out_reg[WORD_W-2:0], 1'b0};
    end
  end

  // Read pointer
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ptr_reg <= PTR_TEMP;
    end else if (cmd_done && is_read) begin
      ptr_reg <= cmd[PTR_MSB:PTR_LSB];
    end else if (read_done) begin
      ptr_reg <= PTR_TEMP;
    end
  end

  // Data pin; result bits D1, D0 stay undriven
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_sio    <= 1'b0;
      o_sio_oe <= 1'b0;
    end else begin
      o_sio    <= sh_out_reg[WORD_W-1];
      o_sio_oe <= in_frame_reg && !pin_lvl.cs_n && rd_phase_reg &&
                  !(rd_sel_reg == PTR_TEMP && bit_reg >= TEMP_Z_BIT);
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_reg  <= CTRL_RESET;
      upper_reg <= UPPER_RESET;
      lower_reg <= LOWER_RESET;
    end else if (cmd_done && !is_sd && !is_read) begin
      case (cmd[2:0])
        CTRL_TAIL:  ctrl_reg <= {CTRL_ZERO, cmd[11:3], CTRL_TAIL};
        LOWER_TAIL: lower_reg <= cmd[WORD_W-1:LIMIT_LSB];
        UPPER_TAIL: upper_reg <= cmd[WORD_W-1:LIMIT_LSB];
        default:    ;
      endcase
    end
  end

  // Shutdown request and wake
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sd_pend_reg <= 1'b0;
    end else if (cmd_done) begin
      sd_pend_reg <= is_sd;
    end
  end

  // ****************************************************************
  // Conversion pacing
  // ****************************************************************
  assign ms_tick    = cyc_reg == 32'(P_CYC_PER_MS - 1);
  assign conv_done  = state_reg == ST_CONV && ms_tick &&
                      ms_reg + 14'h1 >= scale(CONV_MS_FULL, ctrl_reg.res_sel);
  assign enter_down = (conv_done || state_reg == ST_IDLE) && sd_pend_reg;

  function automatic logic [MS_W-1:0] period_ms(input logic [1:0] sel);
    case (sel)
      2'h0:    period_ms = PERIOD_MS_0;
      2'h1:    period_ms = PERIOD_MS_1;
      2'h2:    period_ms = PERIOD_MS_2;
      default: period_ms = PERIOD_MS_3;
    endcase
  endfunction

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= ST_CONV;
      cyc_reg   <= '0;
      ms_reg    <= '0;
    end else begin
      cyc_reg <= ms_tick || state_reg == ST_DOWN ? '0 : cyc_reg + 32'h1;
      if (ms_tick) begin
        ms_reg <= ms_reg + 14'h1;
      end
      case (state_reg)
        ST_CONV: begin
          if (conv_done) begin
            state_reg <= sd_pend_reg ? ST_DOWN : ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (sd_pend_reg) begin
            state_reg <= ST_DOWN;
          // At or past target: a shorter setting never waits for a wrap
          end else if (ms_tick && ms_reg + 14'h1 >=
                       scale(period_ms(ctrl_reg.period_sel),
                             ctrl_reg.res_sel)) begin
            state_reg <= ST_CONV;
            ms_reg    <= '0;
          end
        end
        ST_DOWN: begin
          ms_reg <= '0;
          if (!sd_pend_reg) begin
            state_reg <= ST_CONV;
          end
        end
        default: state_reg <= ST_CONV;
      endcase
    end
  end

  // Result capture with resolution masking
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      temp_reg <= TEMP_RESET;
    end else if (conv_done) begin
      temp_reg <= i_temp_code & ~lsb_mask(ctrl_reg.res_sel);
    end
  end

  // ****************************************************************
  // Alarm evaluation
  // ****************************************************************
  assign mode   = ctrl_reg.thermo_mode;
  // Signed compare over the full 13 bits
  assign hi_now = $signed(i_temp_code & ~lsb_mask(ctrl_reg.res_sel)) >=
                  $signed(upper_reg);
  assign lo_now = $signed(i_temp_code & ~lsb_mask(ctrl_reg.res_sel)) <
                  $signed(lower_reg);

  always_comb begin
    hi_cnt_next = hi_now ? hi_cnt_reg + 3'h1 : 3'h0;
    lo_cnt_next = lo_now ? lo_cnt_reg + 3'h1 : 3'h0;
    if (hi_cnt_next > qlen(ctrl_reg.queue_len)) begin
      hi_cnt_next = qlen(ctrl_reg.queue_len);
    end
    if (lo_cnt_next > qlen(ctrl_reg.queue_len)) begin
      lo_cnt_next = qlen(ctrl_reg.queue_len);
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      hi_cnt_reg <= '0;
      lo_cnt_reg <= '0;
    end else if (conv_done) begin
      hi_cnt_reg <= hi_cnt_next;
      lo_cnt_reg <= lo_cnt_next;
    end
  end

  always_comb begin
    set_evt = 1'b0;
    rel_evt = 1'b0;
    if (conv_done) begin
      if (mode == MODE_LATCH) begin
        set_evt = !active_reg && (arm_low_reg ?
                  lo_cnt_next == qlen(ctrl_reg.queue_len) :
                  hi_cnt_next == qlen(ctrl_reg.queue_len));
      end else begin
        set_evt = hi_cnt_next == qlen(ctrl_reg.queue_len);
        rel_evt = lo_cnt_next == qlen(ctrl_reg.queue_len);
      end
    end
  end

  assign rd_clear = mode == MODE_LATCH && active_reg &&
                    (read_done || enter_down);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      active_reg   <= 1'b0;
      arm_low_reg  <= 1'b0;
      rel_pend_reg <= 1'b0;
    end else begin
      if (mode != MODE_LATCH) begin
        arm_low_reg <= 1'b0;
      end else if (rd_clear) begin
        arm_low_reg <= !arm_low_reg;
      end
      if (mode == MODE_INTCMP) begin
        if (set_evt) begin
          active_reg   <= 1'b1;
          rel_pend_reg <= 1'b0;
        end else if (rel_pend_reg && (read_done || cmd_done)) begin
          active_reg   <= 1'b0;
          rel_pend_reg <= 1'b0;
        end else if (rel_evt && active_reg) begin
          rel_pend_reg <= 1'b1;
        end
      end else begin
        rel_pend_reg <= 1'b0;
        if (set_evt) begin
          active_reg <= 1'b1;
        end else if (rd_clear || (mode != MODE_LATCH && rel_evt)) begin
          active_reg <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_alert      <= 1'b1;
      o_converting <= 1'b0;
      o_power_down <= 1'b0;
    end else begin
      o_alert      <= ctrl_reg.alarm_sense ? active_reg : !active_reg;
      o_converting <= state_reg == ST_CONV;
      o_power_down <= state_reg == ST_DOWN;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_ctrl_fixed: assert property (
    @(posedge i_clk) disable iff (i_reset)
    ctrl_reg.zero == CTRL_ZERO && ctrl_reg.tail == CTRL_TAIL)
    else $error("control word fixed bits wrong");

  a_ptr_back: assert property (
    @(posedge i_clk) disable iff (i_reset)
    read_done |=> ptr_reg == PTR_TEMP)
    else $error("read pointer not returned to result");

  a_idle_down: assert property (
    @(posedge i_clk) disable iff (i_reset)
    state_reg == ST_IDLE && sd_pend_reg |=> state_reg == ST_DOWN)
    else $error("power down not entered from idle");

  a_conv_no_cut: assert property (
    @(posedge i_clk) disable iff (i_reset)
    state_reg == ST_CONV && !conv_done |=> state_reg == ST_CONV)
    else $error("conversion left before completion");

  a_latch_read: assert property (
    @(posedge i_clk) disable iff (i_reset)
    mode == MODE_LATCH && active_reg && read_done && !set_evt
    |=> !active_reg)
    else $error("latched alarm not cleared by read");

  a_latch_down: assert property (
    @(posedge i_clk) disable iff (i_reset)
    mode == MODE_LATCH && active_reg && enter_down |=> !active_reg)
    else $error("latched alarm not cleared by power down");

  // Mask of the resolution in force when the result was taken
  a_res_mask: assert property (
    @(posedge i_clk) disable iff (i_reset)
    conv_done |=> (temp_reg & lsb_mask($past(ctrl_reg.res_sel))) == '0)
    else $error("unused result bits not zero");

  a_alert_sense: assert property (
    @(posedge i_clk) disable iff (i_reset)
    $stable(active_reg) && $stable(ctrl_reg.alarm_sense)
    |-> o_alert == (ctrl_reg.alarm_sense ~^ active_reg))
    else $error("alarm pin polarity wrong");

  a_intcmp_rel: assert property (
    @(posedge i_clk) disable iff (i_reset)
    $past(mode) == MODE_INTCMP && $fell(active_reg)
    |-> $past(read_done) || $past(cmd_done))
    else $error("interrupt-comparator released without communication");

endmodule // tsa_core

`default_nettype wire

// file: src/tsa_pkg.sv
// Constants, field layouts and carriers of the temperature sensor core.
// Assumes one 250 MHz clock and a converter that gives a 13-bit code.
`default_nettype none

package tsa_pkg;

  // ****************************************************************
  // Timebase
  // ****************************************************************
  localparam int CLK_HZ     = 250_000_000;
  localparam int MS_PER_S   = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int MS_W       = 14;

  // Conversion time and start interval at 12-bit resolution, in ms
  localparam logic [MS_W-1:0] CONV_MS_FULL = 14'd240;
  localparam logic [MS_W-1:0] PERIOD_MS_0  = 14'd250;
  localparam logic [MS_W-1:0] PERIOD_MS_1  = 14'd500;
  localparam logic [MS_W-1:0] PERIOD_MS_2  = 14'd1000;
  localparam logic [MS_W-1:0] PERIOD_MS_3  = 14'd8000;

  // ****************************************************************
  // Word layouts
  // ****************************************************************
  localparam int WORD_W    = 16;
  localparam int TEMP_W    = 13;
  localparam int LIMIT_LSB = 3;
  localparam int RD_FLAG   = 15;
  localparam int PTR_MSB   = 4;
  localparam int PTR_LSB   = 3;

  localparam logic [2:0] CTRL_TAIL  = 3'h2;
  localparam logic [2:0] LOWER_TAIL = 3'h4;
  localparam logic [2:0] UPPER_TAIL = 3'h6;
  localparam logic [2:0] TEMP_TAIL  = 3'h4;
  localparam logic [2:0] READ_TAIL  = 3'h0;
  localparam logic [7:0] SD_PATTERN = 8'hff;
  localparam logic [3:0] CTRL_ZERO  = 4'h0;

  localparam logic [3:0] LAST_BIT   = 4'hf;
  localparam logic [3:0] TEMP_Z_BIT = 4'he;

  // Read pointer codes
  localparam logic [1:0] PTR_TEMP  = 2'h0;
  localparam logic [1:0] PTR_CTRL  = 2'h1;
  localparam logic [1:0] PTR_LOWER = 2'h2;
  localparam logic [1:0] PTR_UPPER = 2'h3;

  // Thermostat modes
  localparam logic [1:0] MODE_CMP    = 2'h0;
  localparam logic [1:0] MODE_LATCH  = 2'h1;
  localparam logic [1:0] MODE_INTCMP = 2'h2;

  // Fault queue lengths
  localparam logic [2:0] QLEN_0 = 3'h1;
  localparam logic [2:0] QLEN_1 = 3'h2;
  localparam logic [2:0] QLEN_2 = 3'h4;
  localparam logic [2:0] QLEN_3 = 3'h6;

  // Limits at 0.0625 C per step: 80 C and 75 C
  localparam logic [TEMP_W-1:0] UPPER_RESET = 13'h0500;
  localparam logic [TEMP_W-1:0] LOWER_RESET = 13'h04b0;
  localparam logic [TEMP_W-1:0] TEMP_RESET  = 13'h0000;
  localparam logic [1:0]        RES_FULL    = 2'h3;

  typedef struct packed {
    logic [3:0] zero;
    logic [1:0] period_sel;
    logic [1:0] res_sel;
    logic [1:0] queue_len;
    logic       alarm_sense;
    logic [1:0] thermo_mode;
    logic [2:0] tail;
  } tsa_ctrl_t;

  localparam tsa_ctrl_t CTRL_RESET = 16'h0302;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic sio;
  } tsa_pins_t;

  localparam int PIN_W = 3;

  // Pin levels while the link is idle: select high, clock and data low
  localparam tsa_pins_t PIN_IDLE = 3'h4;

endpackage

`default_nettype wire

// file: src/tsa_sync.sv
// Three-stage input synchroniser with agreement filter and edge pulses.
// Assumes asynchronous inputs; the first stage feeds only the second.
`default_nettype none

module tsa_sync #(
  parameter int           W    = 3,
  parameter logic [W-1:0] IDLE = '0
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  // Raw and cleaned levels, and edge pulses of the cleaned levels
  input  wire logic [W-1:0] i_async,
  output var  logic [W-1:0] o_level,
  output var  logic [W-1:0] o_rise,
  output var  logic [W-1:0] o_fall
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_next;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      // Start at the idle levels so no false edge follows reset
      s1_reg <= IDLE;
      s2_reg <= IDLE;
      s3_reg <= IDLE;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Level moves only where stages two and three agree
  always_comb begin
    level_next = (s2_reg & s3_reg) | (o_level & (s2_reg | s3_reg));
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_level <= IDLE;
      o_rise  <= '0;
      o_fall  <= '0;
    end else begin
      o_level <= level_next;
      o_rise  <= level_next & ~o_level;
      o_fall  <= ~level_next & o_level;
    end
  end

endmodule // tsa_sync

`default_nettype wire

// file: tb/tsa_host.sv
// Host serial controller model for the sensor core bench.
// Assumes i_sio carries the resolved level of the data line.
`default_nettype none

module tsa_host (
  // Clock
  input  wire logic i_clk,
  // Serial pins
  input  wire logic i_sio,
  output var  logic o_cs_n,
  output var  logic o_sck,
  output var  logic o_sio,
  output var  logic o_sio_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_cs_n   = 1'b1;
    o_sck    = 1'b0;
    o_sio    = 1'b0;
    o_sio_oe = 1'b0;
  end

  // Half of the 160 ns link period
  task automatic half();
    repeat (20) @(posedge i_clk);
    #1;
  endtask

  // Read phase then command phase, MSB first, clock idle low
  task automatic frame(input logic [15:0] cmd,
                       output logic [15:0] rd);
    o_cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      half();
      o_sck = 1'b1;
      if (i > 15) rd[i-16] = i_sio;
      half();
      o_sck    = 1'b0;
      o_sio_oe = (i >= 1 && i <= 16);
      if (i >= 1 && i <= 16) o_sio = cmd[i-1];
    end
    half();
    o_cs_n = 1'b1;
    half();
  endtask
endmodule // tsa_host

`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the sensor core through its serial port.
// Assumes a scaled timebase of one clock per millisecond.
`default_nettype none

module tb;
  import tsa_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk, rst, cs_n, sck, h_sio, h_oe;
  logic              d_sio, d_oe, conv, pd, alert;
  logic              last = 1'b0;
  logic [TEMP_W-1:0] code;
  logic [15:0]       rd;
  int                n_mismatch = 0;
  int                n_compared = 0;
  int                n;
  wire logic         sio_w;

  // Undriven line toggles so a stale value never passes
  assign sio_w = d_oe ? d_sio : (h_oe ? h_sio : ~last);
  always @(posedge clk) last <= sio_w;

  tsa_core #(.P_CYC_PER_MS(1)) i_tsa_core (
    .i_clk(clk), .i_reset(rst), .i_cs_n(cs_n), .i_sck(sck),
    .i_sio(sio_w), .o_sio(d_sio), .o_sio_oe(d_oe), .i_temp_code(code),
    .o_converting(conv), .o_power_down(pd), .o_alert(alert));

  tsa_host i_tsa_host (
    .i_clk(clk), .i_sio(sio_w), .o_cs_n(cs_n), .o_sck(sck),
    .o_sio(h_sio), .o_sio_oe(h_oe));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic print_verdict();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask

  task automatic fr(input logic [15:0] cmd);
    i_tsa_host.frame(cmd, rd);
  endtask

  task automatic cw(input int k);
    repeat (k) @(negedge conv);
    repeat (4) @(posedge clk);
    #1;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    rst  = 1'b1;
    code = 13'h0000;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    fr(16'h8008);
    fr(16'h8010); chk(rd, 16'h0302, "ctrl reset");
    fr(16'h8018); chk(rd, 16'h2584, "lower reset");
    fr(16'h0382); chk(rd, 16'h2806, "upper reset");
    chk(16'(alert), 16'h1, "idle alert");
    code = 13'h0505;
    cw(3); chk(16'(alert), 16'h1, "queue early");
    cw(1); chk(16'(alert), 16'h0, "queue met");
    fr(16'h8000); chk(rd & 16'hfffc, 16'h282c, "temp");
    code = 13'h04b0;
    cw(4); chk(16'(alert), 16'h0, "at lower");
    code = 13'h04af;
    cw(4); chk(16'(alert), 16'h1, "below lower");
    fr(16'h0422);
    code = 13'h0507;
    cw(2); chk(16'(alert), 16'h1, "active high");
    fr(16'h8000); chk(rd & 16'hfffc, 16'h2804, "9 bit");
    @(posedge conv);
    n = 0;
    while (conv) begin
      @(posedge clk);
      #1 n++;
    end
    chk(16'(n), 16'd30, "conv time");
    while (!conv) begin
      @(posedge clk);
      #1 n++;
    end
    chk(16'(n), 16'd62, "period");
    code = 13'h04af;
    fr(16'h030a);
    code = 13'h0505;
    cw(2); chk(16'(alert), 16'h0, "latched set");
    fr(16'h8000); chk(16'(alert), 16'h1, "read clear");
    cw(2); chk(16'(alert), 16'h1, "armed low");
    code = 13'h0400;
    cw(2); chk(16'(alert), 16'h0, "low latch");
    code = 13'h0505;
    fr(16'h00ff);
    repeat (300) @(posedge clk);
    #1 chk(16'(pd), 16'h1, "power down");
    chk(16'(conv), 16'h0, "no conv");
    chk(16'(alert), 16'h1, "down clear");
    fr(16'h8000);
    repeat (10) @(posedge clk);
    #1 chk(16'(pd), 16'h0, "wake");
    fr(16'h0312);
    code = 13'h0505;
    cw(2); chk(16'(alert), 16'h0, "intcmp set");
    code = 13'h0400;
    cw(2); chk(16'(alert), 16'h0, "wait comm");
    fr(16'h8000); chk(16'(alert), 16'h1, "comm release");
    fr(16'h031a);
    code = 13'h0505;
    cw(2); chk(16'(alert), 16'h0, "mode 11 set");
    code = 13'h0400;
    cw(2); chk(16'(alert), 16'h1, "mode 11 release");
    print_verdict();
  end
endmodule // tb

`default_nettype wire
